// ===== logic/remote_sensor_status_readout.sv
`timescale 1ns/10ps
module remote_sensor_status_readout (
  input  wire logic             ref_clk,              // Device clock
  input  wire logic             sys_rst,              // Power-on/watchdog reset
  input  wire logic             safingSmReset,        // Safing state machine reset
  input  wire logic             sensorPortClk,        // Link clock pin
  input  wire logic             sensorPortSelN,       // Link select pin
  input  wire logic             sensorPortDataIn,     // Link data from host
  output logic                  sensorPortDataOut,    // Link data to host
  output logic                  sensorPortDataOutEn,  // Drive enable of data out
  input  wire logic [1:0]       sensorOnCmd,          // ON command pulse per channel
  input  wire logic [1:0]       sensorOffCmd,         // OFF command pulse per channel
  input  wire logic [1:0]       stgDetect,            // Current limit detect
  input  wire logic [1:0]       aboveSupply,          // Voltage above supply level
  input  wire logic [1:0]       overHighLimit,        // Current above high limit
  input  wire logic [1:0]       overOpenLimit,        // Current past open limit
  input  wire logic [1:0]       overtempDetect,       // Overtemp detect pulse
  input  wire logic [1:0]       slotCtrlEn,           // Slot control enabled
  input  wire logic [1:0]       avgEnable,            // Averaging config bit 4
  input  wire logic [5:0]       frameValid,           // Valid frame per slot word
  input  wire logic [5:0][9:0]  frameData,            // Decoded data per slot word
  input  wire logic [5:0]       frameInvalid,         // Framing or parity error
  input  wire logic [5:0]       slotViolation,        // Slot timing violation
  input  wire logic [1:0][9:0]  measBase,             // Converter base current
  input  wire logic [1:0][9:0]  measDelta,            // Converter top delta
  output logic [1:0][10:0]      lowThreshold,         // Derived low threshold
  input  wire logic             internalEngineSel,    // Internal safing engine in use
  input  wire logic [1:0]       internalArmSignal,    // Safing engine arm outputs
  input  wire logic [1:0]       armInputPin,          // External arm pins
  input  wire logic             accelPin,             // Accel detect pin
  input  wire logic             accelGoodPulse,       // Good detection event
  input  wire logic             accelBadPulse,        // Bad detection event
  input  wire logic [7:0]       inhibitTimer,         // Inhibit expiration timer
  input  wire logic             inhibitInternalState, // Inhibit internal signal
  input  wire logic             lowSideArmControl     // Low-side arm control pin
);

  // Three-stage synchronisers with agree filter
  logic [rs_readout_pkg::SY_W-1:0] syncA_q, syncB_q, syncC_q, pinLvl_q, pinLvl_d, pinRaw;
  assign pinRaw = {lowSideArmControl, accelPin, armInputPin, sensorPortDataIn, sensorPortSelN, sensorPortClk};

  // Change accepted once second and third stage agree
  always_comb begin
    pinLvl_d = (syncC_q & ~(syncB_q ^ syncC_q)) | (pinLvl_q & (syncB_q ^ syncC_q));
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      // All stages start at the idle levels, so release gives no false select edge
      syncA_q  <= 7'h02;
      syncB_q  <= 7'h02;
      syncC_q  <= 7'h02;
      pinLvl_q <= 7'h02;
    end else begin
      syncA_q  <= pinRaw;
      syncB_q  <= syncA_q;
      syncC_q  <= syncB_q;
      pinLvl_q <= pinLvl_d;
    end
  end

  // CRC x^3+x+1 over word bits 16:0, msb first
  function automatic logic [2:0] crc3(input logic [16:0] body);
    logic [2:0] c;
    logic       fb;
    c = rs_readout_pkg::CRC_SEED;
    for (int i = 16; i >= 0; i--) begin
      fb = c[2] ^ body[i];
      c  = {c[1], c[0] ^ fb, fb};
    end
    return c;
  endfunction

  function automatic logic slotFaultOf(input rs_readout_pkg::chan_status_type c,
                                       input rs_readout_pkg::slot_status_type s);
    return c.shortToGround | c.shortToBattery | c.overcurrentFlag | c.openSensorFlag |
           c.overtempFlag | s.invalid | s.slotError | s.emptyBufferFlag;
  endfunction

  function automatic logic isMapped(input logic [7:0] id);
    return (id == rs_readout_pkg::ID_CH0_SLOT1) || (id == rs_readout_pkg::ID_CH1_SLOT1) ||
           (id == rs_readout_pkg::ID_CH0_SLOT2) || (id == rs_readout_pkg::ID_CH1_SLOT2) ||
           (id == rs_readout_pkg::ID_CH0_SLOT3) || (id == rs_readout_pkg::ID_CH1_SLOT3) ||
           (id == rs_readout_pkg::ID_LEVELS0) || (id == rs_readout_pkg::ID_LEVELS1) ||
           (id == rs_readout_pkg::ID_ARM_STATE);
  endfunction

  rs_readout_pkg::chan_status_type    chQ [2];
  rs_readout_pkg::chan_status_type    chD [2];
  rs_readout_pkg::slot_status_type    slQ [6];
  rs_readout_pkg::slot_status_type    slD [6];
  rs_readout_pkg::current_levels_type lvQ [2];
  logic [10:0] stbCnt_q [2];
  logic [10:0] stbCnt_d [2];
  logic [3:0]  ocCnt_q [2];
  logic [3:0]  ocCnt_d [2];
  logic [3:0]  opCnt_q [2];
  logic [3:0]  opCnt_d [2];
  logic [5:0]  slotFault;
  logic [5:0]  readSlot;
  logic [1:0]  readChan;
  logic [19:0] armWord;
  logic [19:0] respWord;

  // Link framing state
  logic [31:0] rxShift_q, rxShift_d, txShift_q, txShift_d;
  logic [5:0]  bitCnt_q, bitCnt_d;
  logic [7:0]  reqId_q, reqId_d;
  logic        reqOk_q, reqOk_d, sckPrev_q, selPrev_q;
  logic        misoOut_d, misoEn_d, captureEv;

  // Arming state
  logic [1:0]  goodCnt_q, goodCnt_d, badCnt_q, badCnt_d;
  logic        accelValid_q, accelValid_d, inhibitRun_q, inhibitRun_d;

  // Response word for the id latched in the previous frame
  always_comb begin
    logic [16:0] body;
    logic [4:0]  k;
    body     = '0;
    k        = 5'((reqId_q[3:2] * 2) + reqId_q[0]);
    respWord = '0;
    for (int j = 0; j < 6; j++) begin
      slotFault[j] = slotFaultOf(chQ[j % 2], slQ[j]);
    end
    if (reqOk_q) begin
      if (reqId_q == rs_readout_pkg::ID_LEVELS0 || reqId_q == rs_readout_pkg::ID_LEVELS1) begin
        respWord = lvQ[reqId_q[0]];
      end else if (reqId_q == rs_readout_pkg::ID_ARM_STATE) begin
        respWord = armWord;
      end else begin
        body[rs_readout_pkg::FLT_POS] = slotFault[k[2:0]];
        body[14]    = chQ[reqId_q[0]].onState;
        body[13:10] = {1'b0, reqId_q[0], reqId_q[3:2]};
        body[9:0]   = slotFault[k[2:0]] ? {chQ[reqId_q[0]].shortToGround, chQ[reqId_q[0]].shortToBattery,
                      chQ[reqId_q[0]].overcurrentFlag, chQ[reqId_q[0]].openSensorFlag,
                      chQ[reqId_q[0]].overtempFlag, slQ[k[2:0]].invalid, slQ[k[2:0]].emptyBufferFlag,
                      slQ[k[2:0]].slotError, 2'b00} : slQ[k[2:0]].data;
        respWord = {crc3(body), body};
      end
    end
  end

  // Link framing: sample on clock rise, shift out on clock fall, answer out of frame
  always_comb begin
    logic sckRise, sckFall, selStart, selEnd;
    sckRise   = pinLvl_q[rs_readout_pkg::SY_SCK] & ~sckPrev_q;
    sckFall   = ~pinLvl_q[rs_readout_pkg::SY_SCK] & sckPrev_q;
    selStart  = ~pinLvl_q[rs_readout_pkg::SY_SEL] & selPrev_q;
    selEnd    = pinLvl_q[rs_readout_pkg::SY_SEL] & ~selPrev_q;
    rxShift_d = rxShift_q;
    txShift_d = txShift_q;
    bitCnt_d  = bitCnt_q;
    reqId_d   = reqId_q;
    reqOk_d   = reqOk_q;
    misoOut_d = sensorPortDataOut;
    misoEn_d  = sensorPortDataOutEn;
    captureEv = 1'b0;
    if (selStart) begin
      captureEv = 1'b1;
      txShift_d = {12'h000, respWord};
      misoOut_d = 1'b0;
      misoEn_d  = 1'b1;
      bitCnt_d  = '0;
    end else if (selEnd) begin
      misoEn_d = 1'b0;
      // Short or long frames drop the request rather than guess an id
      reqOk_d  = (bitCnt_q == rs_readout_pkg::FRAME_BITS_CNT) && isMapped(rxShift_q[31:24]) &&
                 (rxShift_q[rs_readout_pkg::PAD_MSB:rs_readout_pkg::PAD_LSB] == 8'h00);
      reqId_d  = rxShift_q[rs_readout_pkg::ID_MSB:rs_readout_pkg::ID_LSB];
    end else if (~pinLvl_q[rs_readout_pkg::SY_SEL]) begin
      if (sckRise) begin
        rxShift_d = {rxShift_q[30:0], pinLvl_q[rs_readout_pkg::SY_MOSI]};
        bitCnt_d  = (bitCnt_q == 6'h3F) ? bitCnt_q : bitCnt_q + 6'h01;
      end
      if (sckFall) begin
        txShift_d = {txShift_q[30:0], 1'b0};
        misoOut_d = txShift_q[30];
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rxShift_q           <= '0;
      txShift_q           <= '0;
      bitCnt_q            <= '0;
      reqId_q             <= '0;
      reqOk_q             <= 1'b0;
      sckPrev_q           <= 1'b0;
      selPrev_q           <= 1'b1;
      sensorPortDataOut   <= 1'b0;
      sensorPortDataOutEn <= 1'b0;
    end else begin
      rxShift_q           <= rxShift_d;
      txShift_q           <= txShift_d;
      bitCnt_q            <= bitCnt_d;
      reqId_q             <= reqId_d;
      reqOk_q             <= reqOk_d;
      sckPrev_q           <= pinLvl_q[rs_readout_pkg::SY_SCK];
      selPrev_q           <= pinLvl_q[rs_readout_pkg::SY_SEL];
      sensorPortDataOut   <= misoOut_d;
      sensorPortDataOutEn <= misoEn_d;
    end
  end

  // Reads clear in the capture cycle itself, after the word is taken
  always_comb begin
    for (int j = 0; j < 6; j++) begin
      readSlot[j] = captureEv && reqOk_q && (reqId_q[7:4] == 4'h5) && !reqId_q[1] &&
                    (reqId_q[3:2] != 2'b11) && (5'((reqId_q[3:2] * 2) + reqId_q[0]) == 5'(j));
    end
    readChan = {readSlot[5] | readSlot[3] | readSlot[1], readSlot[4] | readSlot[2] | readSlot[0]};
  end

  // Channel and slot status; hardware sets win over read clears
  always_comb begin
    logic [1:0] stgSet, tmpSet, stbSet, ocSet, opSet, newFault, offClr;
    {stgSet, tmpSet, stbSet, ocSet, opSet, newFault, offClr} = '0;
    for (int c = 0; c < 2; c++) begin
      chD[c]      = chQ[c];
      offClr[c]   = safingSmReset | sensorOffCmd[c];
      stgSet[c]   = stgDetect[c];
      tmpSet[c]   = overtempDetect[c];
      stbSet[c]   = aboveSupply[c] && (stbCnt_q[c] == rs_readout_pkg::STB_CYC);
      ocSet[c]    = ocCnt_q[c] == rs_readout_pkg::UPDN_LIMIT;
      opSet[c]    = opCnt_q[c] == rs_readout_pkg::UPDN_LIMIT;
      stbCnt_d[c] = (!aboveSupply[c] || safingSmReset) ? '0 :
                    (stbCnt_q[c] == rs_readout_pkg::STB_CYC) ? stbCnt_q[c] : stbCnt_q[c] + 11'h001;
      ocCnt_d[c]  = safingSmReset ? '0 : overHighLimit[c] ?
                    ((ocCnt_q[c] == rs_readout_pkg::UPDN_LIMIT) ? ocCnt_q[c] : ocCnt_q[c] + 4'h1) :
                    ((ocCnt_q[c] == 4'h0) ? ocCnt_q[c] : ocCnt_q[c] - 4'h1);
      opCnt_d[c]  = safingSmReset ? '0 : overOpenLimit[c] ?
                    ((opCnt_q[c] == rs_readout_pkg::UPDN_LIMIT) ? opCnt_q[c] : opCnt_q[c] + 4'h1) :
                    ((opCnt_q[c] == 4'h0) ? opCnt_q[c] : opCnt_q[c] - 4'h1);
      newFault[c] = (stgSet[c] & ~chQ[c].shortToGround) | (stbSet[c] & ~chQ[c].shortToBattery) |
                    (ocSet[c] & ~chQ[c].overcurrentFlag) | (opSet[c] & ~chQ[c].openSensorFlag) |
                    (tmpSet[c] & ~chQ[c].overtempFlag);
      // Protective clears beat a simultaneous ON
      if (sensorOnCmd[c]) chD[c].onState = 1'b1;
      if (offClr[c] | stgSet[c] | tmpSet[c]) chD[c].onState = 1'b0;
      if (offClr[c]) chD[c].shortToGround = 1'b0;
      if (stgSet[c]) chD[c].shortToGround = 1'b1;
      if (offClr[c] | readChan[c]) chD[c].shortToBattery = 1'b0;
      if (stbSet[c]) chD[c].shortToBattery = 1'b1;
      if (offClr[c] | readChan[c]) chD[c].overcurrentFlag = 1'b0;
      if (ocSet[c]) chD[c].overcurrentFlag = 1'b1;
      if (offClr[c] | readChan[c]) chD[c].openSensorFlag = 1'b0;
      if (opSet[c]) chD[c].openSensorFlag = 1'b1;
      if (offClr[c]) chD[c].overtempFlag = 1'b0;
      if (tmpSet[c]) chD[c].overtempFlag = 1'b1;
    end
    for (int k = 0; k < 6; k++) begin
      slD[k] = slQ[k];
      if (offClr[k % 2] | readSlot[k]) slD[k].data = '0;
      if (frameValid[k]) slD[k].data = frameData[k];
      if (offClr[k % 2] | readSlot[k] | newFault[k % 2] | frameValid[k]) slD[k].invalid = 1'b0;
      if (frameInvalid[k]) slD[k].invalid = 1'b1;
      if (offClr[k % 2] | readSlot[k] | newFault[k % 2] | frameValid[k]) slD[k].slotError = 1'b0;
      if (slotCtrlEn[k % 2] & slotViolation[k]) slD[k].slotError = 1'b1;
      if (readSlot[k] && !(slotFault[k] && !slQ[k].emptyBufferFlag)) slD[k].emptyBufferFlag = 1'b1;
      if (frameValid[k] | newFault[k % 2] | frameInvalid[k] | (slotCtrlEn[k % 2] & slotViolation[k])) begin
        slD[k].emptyBufferFlag = 1'b0;
      end
      if (safingSmReset) slD[k].emptyBufferFlag = 1'b1;
    end
  end

  // Arming word from live levels; counters judge accel validity
  always_comb begin
    armWord      = '0;
    armWord[rs_readout_pkg::ARM_INH_INT] = inhibitInternalState;
    armWord[rs_readout_pkg::ARM_INH_RUN] = inhibitRun_q;
    armWord[rs_readout_pkg::ARM_ACL_PIN] = pinLvl_q[rs_readout_pkg::SY_ACL];
    armWord[rs_readout_pkg::ARM_ACCEL_DETECT_VALID] = accelValid_q;
    armWord[rs_readout_pkg::ARM_INT_LSB +: 2] = internalEngineSel ? internalArmSignal :
                  pinLvl_q[rs_readout_pkg::SY_ARM1:rs_readout_pkg::SY_ARM0];
    armWord[rs_readout_pkg::ARM_LOW_SIDE] = pinLvl_q[rs_readout_pkg::SY_LOWSIDE];
    goodCnt_d    = goodCnt_q;
    badCnt_d     = badCnt_q;
    if (accelGoodPulse) begin
      goodCnt_d = (goodCnt_q == rs_readout_pkg::ACCEL_GOOD_COUNT_LIM) ? goodCnt_q : goodCnt_q + 2'h1;
      badCnt_d  = '0;
    end else if (accelBadPulse) begin
      badCnt_d  = (badCnt_q == rs_readout_pkg::ACCEL_BAD_COUNT_LIM) ? badCnt_q : badCnt_q + 2'h1;
      goodCnt_d = '0;
    end
    accelValid_d = accelValid_q;
    if (badCnt_q == rs_readout_pkg::ACCEL_BAD_COUNT_LIM) accelValid_d = 1'b0;
    if (goodCnt_q == rs_readout_pkg::ACCEL_GOOD_COUNT_LIM) accelValid_d = 1'b1;
    inhibitRun_d = !safingSmReset && (inhibitTimer != 8'h00);
    if (safingSmReset) begin
      goodCnt_d    = '0;
      badCnt_d     = '0;
      accelValid_d = 1'b0;
    end
  end

  // Status, counters, levels and thresholds
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      for (int c = 0; c < 2; c++) begin
        chQ[c]          <= '0;
        stbCnt_q[c]     <= '0;
        ocCnt_q[c]      <= '0;
        opCnt_q[c]      <= '0;
        lvQ[c]          <= {rs_readout_pkg::DELTA_RESET, rs_readout_pkg::BASE_RESET};
        lowThreshold[c] <= '0;
      end
      for (int k = 0; k < 6; k++) begin
        slQ[k] <= '{data: '0, invalid: 1'b0, slotError: 1'b0, emptyBufferFlag: 1'b1};
      end
      goodCnt_q    <= '0;
      badCnt_q     <= '0;
      accelValid_q <= 1'b0;
      inhibitRun_q <= 1'b0;
    end else begin
      for (int c = 0; c < 2; c++) begin
        chQ[c]          <= chD[c];
        stbCnt_q[c]     <= stbCnt_d[c];
        ocCnt_q[c]      <= ocCnt_d[c];
        opCnt_q[c]      <= opCnt_d[c];
        lvQ[c]          <= {measDelta[c], measBase[c]};
        lowThreshold[c] <= {1'b0, lvQ[c].baseCurrent} + (avgEnable[c] ? {1'b0, lvQ[c].topCurrentDelta} :
                           {2'b00, lvQ[c].topCurrentDelta[9:1]});
      end
      for (int k = 0; k < 6; k++) begin
        slQ[k] <= slD[k];
      end
      goodCnt_q    <= goodCnt_d;
      badCnt_q     <= badCnt_d;
      accelValid_q <= accelValid_d;
      inhibitRun_q <= inhibitRun_d;
    end
  end

  // Checks
  a_crc_on_word: assert property (@(posedge ref_clk) disable iff (sys_rst)
    captureEv && reqOk_q && reqId_q[7:4] == 4'h5 && !reqId_q[1] && reqId_q[3:2] != 2'b11
    |=> txShift_q[19:17] == crc3(txShift_q[16:0])) else $error("crc mismatch in word");
  a_flag_capture: assert property (@(posedge ref_clk) disable iff (sys_rst)
    readSlot[0] && !slotFault[0] |=> txShift_q[15] == 1'b0 && txShift_q[9:0] == $past(slQ[0].data))
    else $error("data not captured before clear");
  a_stg_forces_off: assert property (@(posedge ref_clk) disable iff (sys_rst)
    stgDetect[0] |=> !chQ[0].onState && chQ[0].shortToGround) else $error("stg did not force off");
  a_stg_kept_read: assert property (@(posedge ref_clk) disable iff (sys_rst)
    chQ[0].shortToGround && !sensorOffCmd[0] && !safingSmReset |=> chQ[0].shortToGround)
    else $error("stg lost without off");
  a_stb_filter: assert property (@(posedge ref_clk) disable iff (sys_rst)
    $rose(chQ[0].shortToBattery) |-> $past(stbCnt_q[0]) == rs_readout_pkg::STB_CYC)
    else $error("stb set before filter time");
  a_data_load: assert property (@(posedge ref_clk) disable iff (sys_rst)
    frameValid[0] |=> slQ[0].data == $past(frameData[0]) && !slQ[0].emptyBufferFlag)
    else $error("frame data not loaded");
  a_accel_valid: assert property (@(posedge ref_clk) disable iff (sys_rst)
    goodCnt_q == 2'h3 && !safingSmReset |=> accelValid_q) else $error("accel valid not set");
  a_inhibit_run: assert property (@(posedge ref_clk) disable iff (sys_rst)
    inhibitTimer != 8'h00 && !safingSmReset |=> armWord[8]) else $error("inhibit bit not shown");
  a_open_count: assert property (@(posedge ref_clk) disable iff (sys_rst)
    overOpenLimit[0] && !safingSmReset && !sensorOffCmd[0] [*8] ##1 !sensorOffCmd[0] && !safingSmReset
    |=> chQ[0].openSensorFlag) else $error("open flag not set after count");

endmodule // remote_sensor_status_readout

// ===== include/rs_readout_pkg.sv
// Function
// - Bit 15 of each sensor word is the fault flag choosing data or fault layout.
// - Three-bit CRC in bits 19:17 covers word bits 16 down to 0.
// - Fault flag is set while any fault bit is one, clear when all zero.
// - On/off bit resets 0, set by ON, cleared by OFF, safing reset, SHORT_TO_GROUND, overtemp.
// - Logical channel ID gives channel and slot of the register that was read.
// - Ten-bit data loads on valid frame; cleared by safing reset, read or OFF.
// - Short-to-ground resets 0, cleared only by safing reset or OFF, never by read.
// - Short-to-battery sets after filter time; cleared by reset, read, commanded OFF only.
// - Overcurrent sets via up/down counter; cleared by safing reset, read or OFF.
// - Open sensor sets via up/down counter; cleared by safing reset, read or OFF.
// - Overtemp sets on detection; cleared only by safing reset or OFF.
// - Invalid sets on framing error; cleared by reset, read, OFF, faults, valid data.
// - Empty-buffer resets 1, sets on read without faults, clears on frame or fault.
// - Slot error sets when slot control on; cleared by reset, read, OFF, faults, data.
// - Base current is ten bits in the low half, reset value 0x0A1.
// - Delta resets 0x103; low threshold is base plus half or full delta.
// - Arming bits follow internal engine when selected, else external arm pins.
// - Accel valid resets 0, sets at good count 3, clears at bad limit.
// - Arming register echoes live accel pin and low-side arm control.
// - Inhibit timer bit reads 0 when timer is zero, resets 0.
// - Inhibit timer bit reads 1 while its timer counts.
package rs_readout_pkg;

  // Link frame layout
  localparam int          FRAME_BITS     = 32;
  localparam int          ID_MSB         = 31;
  localparam int          ID_LSB         = 24;
  localparam int          PAD_MSB        = 23;
  localparam int          PAD_LSB        = 16;
  localparam logic [5:0]  FRAME_BITS_CNT = 6'h20;

  // Register identifiers
  localparam logic [7:0]  ID_CH0_SLOT1   = 8'h50;
  localparam logic [7:0]  ID_CH1_SLOT1   = 8'h51;
  localparam logic [7:0]  ID_CH0_SLOT2   = 8'h54;
  localparam logic [7:0]  ID_CH1_SLOT2   = 8'h55;
  localparam logic [7:0]  ID_CH0_SLOT3   = 8'h58;
  localparam logic [7:0]  ID_CH1_SLOT3   = 8'h59;
  localparam logic [7:0]  ID_LEVELS0     = 8'h5C;
  localparam logic [7:0]  ID_LEVELS1     = 8'h5D;
  localparam logic [7:0]  ID_ARM_STATE   = 8'h6A;

  // Sensor word fields
  localparam int          CRC_LSB        = 17;
  localparam int          FLT_POS        = 15;
  localparam logic [2:0]  CRC_SEED       = 3'h7;

  // Arming word fields
  localparam int          ARM_INH_INT    = 9;
  localparam int          ARM_INH_RUN    = 8;
  localparam int          ARM_ACL_PIN    = 7;
  localparam int          ARM_ACCEL_DETECT_VALID  = 6;
  localparam int          ARM_INT_LSB    = 2;
  localparam int          ARM_LOW_SIDE   = 1;

  // Reset values
  localparam logic [9:0]  BASE_RESET     = 10'h0A1;
  localparam logic [9:0]  DELTA_RESET    = 10'h103;

  // Timing and counts
  localparam int          CLK_PERIOD_NS  = 10;
  localparam int          STB_FILTER_NS  = 10000;
  localparam logic [10:0] STB_CYC        = 11'((STB_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0]  UPDN_LIMIT     = 4'h8;
  localparam logic [1:0]  ACCEL_GOOD_COUNT_LIM   = 2'h3;
  localparam logic [1:0]  ACCEL_BAD_COUNT_LIM    = 2'h2;

  // Synchroniser lane positions
  localparam int          SY_SCK         = 0;
  localparam int          SY_SEL         = 1;
  localparam int          SY_MOSI        = 2;
  localparam int          SY_ARM0        = 3;
  localparam int          SY_ARM1        = 4;
  localparam int          SY_ACL         = 5;
  localparam int          SY_LOWSIDE     = 6;
  localparam int          SY_W           = 7;

  typedef struct packed {
    logic onState;
    logic shortToGround;
    logic shortToBattery;
    logic overcurrentFlag;
    logic openSensorFlag;
    logic overtempFlag;
  } chan_status_type;

  typedef struct packed {
    logic [9:0] data;
    logic       invalid;
    logic       slotError;
    logic       emptyBufferFlag;
  } slot_status_type;

  typedef struct packed {
    logic [9:0] topCurrentDelta;
    logic [9:0] baseCurrent;
  } current_levels_type;

endpackage

// ===== verif/host_link_model.sv
`timescale 1ns/10ps
module host_link_model (
  output logic      sensorPortClk,    // Link clock, idle low
  output logic      sensorPortSelN,   // Select, active low
  output logic      sensorPortDataIn, // Data to device
  input  wire logic sensorPortDataOut // Data from device
);
  initial begin
    sensorPortClk = 1'b0;
    sensorPortSelN = 1'b1;
    sensorPortDataIn = 1'b0;
  end
  // One frame msb first; the answer belongs to the previous request
  task automatic xfer(input logic [7:0] id, output logic [31:0] ans);
    logic [31:0] tx;
    tx = {id, 24'h00_0000};
    sensorPortSelN = 1'b0;
    #200;
    for (int i = 31; i >= 0; i--) begin
      sensorPortDataIn = tx[i];
      #62.5 sensorPortClk = 1'b1;
      ans[i] = sensorPortDataOut;
      #62.5 sensorPortClk = 1'b0;
    end
    sensorPortDataIn = ~tx[0]; // Released line shows no stale bit
    sensorPortSelN = 1'b1;
    #200;
  endtask
endmodule // host_link_model

// ===== verif/tb.sv
`timescale 1ns/10ps
module tb;
  logic ref_clk = 0, sys_rst = 1, safingSmReset = 0, internalEngineSel = 0, accelPin = 1;
  logic accelGoodPulse = 0, accelBadPulse = 0, inhibitInternalState = 1, lowSideArmControl = 1;
  logic [1:0] sensorOnCmd = 0, sensorOffCmd = 0, stgDetect = 0, aboveSupply = 0, overHighLimit = 0;
  logic [1:0] overOpenLimit = 0, overtempDetect = 0, slotCtrlEn = 0, avgEnable = 2'h2, armInputPin = 2'h2;
  logic [1:0] internalArmSignal = 0;
  logic [5:0] frameValid = 0, frameInvalid = 0, slotViolation = 0;
  logic [5:0][9:0] frameData = '0;
  logic [1:0][9:0] measBase = {10'h010, 10'h0A1}, measDelta = {10'h020, 10'h103};
  logic [1:0][10:0] lowThreshold;
  logic [7:0] inhibitTimer = 8'h05;
  logic sensorPortClk, sensorPortSelN, sensorPortDataIn, sensorPortDataOut, sensorPortDataOutEn;
  int failures = 0, total_checks = 0;
  remote_sensor_status_readout i_dut (.*);
  host_link_model i_host (.*);
  initial forever #5 ref_clk = ~ref_clk;
  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Slot word with its three-bit check code on top
  function automatic logic [19:0] word(input logic [16:0] d);
    logic [2:0] c;
    c = 3'h7;
    for (int i = 16; i >= 0; i--) c = {c[1], c[0] ^ c[2] ^ d[i], c[2] ^ d[i]};
    return {c, d};
  endfunction
  // Second frame is a side-effect-free read that carries the answer
  task automatic rd(input logic [7:0] id, input logic [19:0] exp, input string what);
    logic [31:0] ans;
    i_host.xfer(id, ans);
    fork
      i_host.xfer(8'h6A, ans);
      begin
        #1000;
        check("drive en", {31'h0, sensorPortDataOutEn}, 32'h1);
      end
    join
    check(what, ans, {12'h000, exp});
    check("idle en", {31'h0, sensorPortDataOutEn}, 32'h0);
  endtask
  task automatic t_levels;
    rd(8'h5C, 20'h4_0CA1, "levels0");
    check("thr0", 32'(lowThreshold[0]), 32'h0000_0122);
    check("thr1", 32'(lowThreshold[1]), 32'h0000_0030);
  endtask
  task automatic t_data;
    rd(8'h50, word(17'h0_8008), "empty");
    sensorOnCmd = 2'h1;
    frameValid = 6'h21;
    frameData[0] = 10'h155;
    frameData[5] = 10'h2AA;
    step(1);
    {sensorOnCmd, frameValid} = '0;
    rd(8'h50, word(17'h0_4155), "data");
    rd(8'h50, word(17'h0_C008), "reread");
    rd(8'h59, word(17'h0_1AAA), "ch1s3");
  endtask
  task automatic t_stg;
    sensorOnCmd = 2'h1;
    step(1);
    sensorOnCmd = 2'h0;
    stgDetect = 2'h1;
    step(1);
    stgDetect = 2'h0;
    repeat (2) rd(8'h50, word(17'h0_8200), "stg");
    sensorOffCmd = 2'h1;
    step(1);
    sensorOffCmd = 2'h0;
    rd(8'h50, word(17'h0_0000), "off");
  endtask
  task automatic t_arm;
    rd(8'h6A, 20'h0_038A, "armext");
    {internalEngineSel, internalArmSignal, inhibitTimer, accelPin} = {3'h5, 8'h00, 1'b0};
    repeat (3) begin
      accelGoodPulse = 1'b1;
      step(1);
      accelGoodPulse = 1'b0;
      step(1);
    end
    rd(8'h6A, 20'h0_0246, "armint");
  endtask
  // Counted faults on ch1, open count on ch0, then safing and a framing error
  task automatic t_faults;
    {overHighLimit, overOpenLimit} = 4'h9;
    step(10);
    {overHighLimit, overOpenLimit, overtempDetect, slotCtrlEn, slotViolation} = {4'h0, 2'h2, 2'h2, 6'h02};
    step(1);
    {overtempDetect, slotViolation} = '0;
    rd(8'h51, word(17'h0_90A4), "ch1 faults");
    rd(8'h51, word(17'h0_9020), "read clears");
    safingSmReset = 1'b1;
    step(1);
    {safingSmReset, frameInvalid} = {1'b0, 6'h08};
    step(1);
    frameInvalid = '0;
    rd(8'h51, word(17'h0_9008), "safing");
    rd(8'h55, word(17'h0_9410), "invalid");
  endtask
  // Single exit of the run
  task automatic close_out;
    if (failures == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    step(16);
    sys_rst = 1'b0;
    step(10);
    t_levels();
    t_data();
    t_stg();
    t_faults();
    t_arm();
    close_out();
  end
  // Whole run is about 12400 cycles
  initial begin
    repeat (60000) @(posedge ref_clk);
    failures++;
    close_out();
  end
endmodule // tb
